// File: irq_ctrl_defs.vh
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// register byte offsets, low 8 address bits decoded
`define OFS_SYS_CTRL 8'h00
`define OFS_SENSE 8'h04
`define OFS_ENABLE 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PRIO_A 8'h10
`define OFS_PRIO_B 8'h14

// reset values
`define RST_SYS_CTRL 8'h09
`define RST_SENSE 8'h00
`define RST_ENABLE 8'h00
`define RST_STATUS 8'h00
`define RST_PRIO_A 8'h00
`define RST_PRIO_B 8'h00

// field positions
`define BIT_NONMASK_EDGE 2
`define BIT_PRIO_TMR8_CH01 7
`define BIT_PRIO_TMR8_CH23 6
`define BIT_PRIO_SERIAL_CH0 3
`define BIT_PRIO_SERIAL_CH1 2
`define STATUS_USED_MASK 8'h3f

// vector numbers
`define VEC_NONMASK 8'h07
`define VEC_EXT_BASE 8'h0c
`define VEC_SERIAL_CH0_BASE 8'h34
`define VEC_SERIAL_CH1_BASE 8'h38

// source counts
`define NUM_EXT 6
`define NUM_INT 27
`define NUM_SRC 33

`endif

// File: ext_req_channel.v
`include "irq_ctrl_defs.vh"

module ext_req_channel (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // pin and configuration
    input wire req_pin_n,
    input wire sense_edge,
    input wire standby_clr,
    // software access
    input wire status_read,
    input wire status_write,
    input wire status_wdata,
    // exception acknowledge for this channel
    input wire ack,
    // state
    output reg flag_q
);

    reg sync1_q;
    reg sync2_q;
    reg prev_q;
    reg armed_q;
    wire set_ev;
    wire clr_ev;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser, first stage read by second stage only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= req_pin_n;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // level mode: pin low; edge mode: high to low
    assign set_ev = sense_edge ? (prev_q & ~sync2_q) : ~sync2_q;
    // software clear only after a read saw the flag set; auto clear on ack
    assign clr_ev = (status_write & ~status_wdata & armed_q)
        | (ack & (sense_edge | sync2_q));

    ////////////////////////////////////////////////////////////////////////
    // flag: standby clear wins over all; set wins over the write and ack clears in the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else if (standby_clr) begin
            flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (set_ev) begin
                flag_q <= 1'b1;
            end else if (clr_ev) begin
                flag_q <= 1'b0;
            end
            // writing 1 never sets; a write consumes the read arming
            if (status_read) begin
                armed_q <= flag_q;
            end else if (status_write) begin
                armed_q <= 1'b0;
            end
        end
    end

endmodule

// File: prio_select.v
`include "irq_ctrl_defs.vh"

module prio_select (
    // candidates, index order equals ascending vector number
    input wire [`NUM_SRC-1:0] req,
    input wire [`NUM_SRC-1:0] level,
    // result
    output reg found,
    output reg [5:0] index
);

    integer i;

    // scan from the top so the lowest index of the best level wins last
    always @* begin
        found = 1'b0;
        index = 6'h00;
        for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (req[i] & level[i]) begin
                found = 1'b1;
                index = i[5:0];
            end
        end
        if (!found) begin
            for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (req[i]) begin
                    found = 1'b1;
                    index = i[5:0];
                end
            end
        end
    end

endmodule

// File: external_irq_priority_ctrl.v
`include "irq_ctrl_defs.vh"

// Behaviour
// - reset or hardware standby clears priority, status, enable and sense registers
// - prio_tmr8_ch01 places 8-bit timer channels 0/1 at high level
// - prio_tmr8_ch23 places 8-bit timer channels 2/3 at high level
// - prio_serial_ch0 places serial channel 0 at high level
// - prio_serial_ch1 places serial channel 1 at high level
// - priority B bits 5,4,1,0 store values without priority effect
// - status bits 7 and 6 ignore writes and read zero
// - status flag clears on write 0 after reading it as 1
// - level mode sets flag while request pin is low
// - edge mode sets flag on high to low pin transition
// - level mode flag clears on exception handling with pin high
// - edge mode flag clears on exception handling for that channel
// - enable bits 5..0 enable external channels individually
// - enable and sense bits 7,6 are plain storage
// - sense bit 0 selects low level, 1 selects falling edge
// - nonmaskable request ignores cpu masks and outranks everything
// - system control select bit picks nonmaskable pin edge
// - edge select resets to 0; 0 falling, 1 rising
// - nonmaskable request uses vector 7
// - external channels 0..5 use vectors 12..17
// - nonmaskable and channels 0..2 wake from software standby, others not
// - pins detected whatever their direction; software should keep them inputs
// - accepts 27 peripheral requests with levels from both priority registers
// - same level favours smaller vector; default order after reset
module external_irq_priority_ctrl (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // external pins
    input wire nonmask_pin,
    input wire [5:0] ext_req_pin_n,
    input wire hw_standby,
    // on-chip peripheral requests and power state
    input wire [26:0] periph_req,
    input wire sw_standby,
    // cpu exception logic
    input wire cpu_int_mask,
    input wire exc_ack,
    input wire [7:0] exc_ack_vector,
    output reg irq_req,
    output reg [7:0] irq_vector,
    output reg nonmask_req,
    output reg wake_req
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    reg [7:0] sys_ctrl_q;
    reg [7:0] sense_q;
    reg [7:0] enable_q;
    reg [7:0] prio_a_q;
    reg [7:0] prio_b_q;
    wire [5:0] ext_req_flag;
    wire [7:0] status_rd;

    reg stby_s1_q;
    reg stby_s2_q;
    reg nm_s1_q;
    reg nm_s2_q;
    reg nm_prev_q;
    reg nm_pend_q;

    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] addr_q;
    wire addr_phase;
    wire wr_en;
    wire status_read;
    wire status_write;
    reg [7:0] rd_mux;

    wire [`NUM_SRC-1:0] src_req;
    reg [`NUM_SRC-1:0] src_lvl;
    wire sel_found;
    wire [5:0] sel_index;
    reg [7:0] sel_vector;
    wire nm_edge_sel;
    wire nm_event;
    wire ext_ack_any;
    wire [7:0] ack_offset;
    wire [5:0] ext_ack_hot;
    wire [5:0] ext_active;

    ////////////////////////////////////////////////////////////////////////
    // vector number per source index; ascending, so index order is priority
    // reserved vectors are skipped, so each group sits at its own base;
    // the table must stay ascending or the scan in prio_select would
    // favour a larger vector over a smaller one at the same level
    function [7:0] src_vector;
        input [5:0] idx;
        begin
            case (idx)
                6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd5:
                    src_vector = `VEC_EXT_BASE + {2'h0, idx};
                6'd6: src_vector = 8'h14;
                6'd7: src_vector = 8'h17;
                6'd8, 6'd9, 6'd10: src_vector = 8'h10 + {2'h0, idx};
                6'd11, 6'd12, 6'd13: src_vector = 8'h11 + {2'h0, idx};
                6'd14, 6'd15, 6'd16: src_vector = 8'h12 + {2'h0, idx};
                6'd17, 6'd18, 6'd19, 6'd20, 6'd21, 6'd22, 6'd23, 6'd24:
                    src_vector = 8'h13 + {2'h0, idx};
                6'd25, 6'd26, 6'd27, 6'd28:
                    src_vector = `VEC_SERIAL_CH0_BASE + {2'h0, idx} - 8'h19;
                6'd29, 6'd30, 6'd31, 6'd32:
                    src_vector = `VEC_SERIAL_CH1_BASE + {2'h0, idx} - 8'h1d;
                default: src_vector = 8'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for hardware standby and the nonmaskable pin
    // these flops reset to the idle pin level, so releasing reset with
    // the pin high shows no false edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stby_s1_q <= 1'b0;
            stby_s2_q <= 1'b0;
            nm_s1_q <= 1'b1;
            nm_s2_q <= 1'b1;
            nm_prev_q <= 1'b1;
        end else begin
            stby_s1_q <= hw_standby;
            stby_s2_q <= stby_s1_q;
            nm_s1_q <= nonmask_pin;
            nm_s2_q <= nm_s1_q;
            nm_prev_q <= nm_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes zero wait, reads one wait state
    // the read wait lets read data come from a flop and still see a write
    // that completed in the cycle just before
    // hsize is ignored: every register is one whole word

    assign addr_phase = hsel & htrans[1] & hready;
    assign hreadyout = ~rd_pend_q;
    assign hresp = 1'b0;
    assign wr_en = wr_pend_q;
    assign status_write = wr_en & (addr_q == `OFS_STATUS);
    assign status_read = rd_pend_q & (addr_q == `OFS_STATUS);

    // address phase capture
    // only the low address byte is decoded, so the map repeats every 256 bytes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            rd_pend_q <= addr_phase & ~hwrite;
            if (addr_phase) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // flags clear through their own channel, never by a plain write
    // status reads show only the six flags
    assign status_rd = {2'b00, ext_req_flag} & `STATUS_USED_MASK;

    // read mux, unmapped offsets read zero
    // decoded from the captured address, not the live bus
    always @* begin
        case (addr_q)
            `OFS_SYS_CTRL: rd_mux = sys_ctrl_q;
            `OFS_SENSE: rd_mux = sense_q;
            `OFS_ENABLE: rd_mux = enable_q;
            `OFS_STATUS: rd_mux = status_rd;
            `OFS_PRIO_A: rd_mux = prio_a_q;
            `OFS_PRIO_B: rd_mux = prio_b_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data register
    // only a read data phase loads it, so it holds until the next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata <= {24'h000000, rd_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; reserved bits are kept as plain storage
    // standby wins over a write in the same cycle, so software cannot
    // keep a value through it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_ctrl_q <= `RST_SYS_CTRL;
            sense_q <= `RST_SENSE;
            enable_q <= `RST_ENABLE;
            prio_a_q <= `RST_PRIO_A;
            prio_b_q <= `RST_PRIO_B;
        end else if (stby_s2_q) begin
            sys_ctrl_q <= `RST_SYS_CTRL;
            sense_q <= `RST_SENSE;
            enable_q <= `RST_ENABLE;
            prio_a_q <= `RST_PRIO_A;
            prio_b_q <= `RST_PRIO_B;
        end else if (wr_en) begin
            case (addr_q)
                `OFS_SYS_CTRL: sys_ctrl_q <= hwdata[7:0];
                `OFS_SENSE: sense_q <= hwdata[7:0];
                `OFS_ENABLE: enable_q <= hwdata[7:0];
                `OFS_PRIO_A: prio_a_q <= hwdata[7:0];
                `OFS_PRIO_B: prio_b_q <= hwdata[7:0];
                default: sys_ctrl_q <= sys_ctrl_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external request channels; pins are sampled whatever their direction
    assign ext_ack_any = exc_ack & (exc_ack_vector >= `VEC_EXT_BASE)
        & (exc_ack_vector < `VEC_EXT_BASE + 8'h06);

    // distance of the acknowledged vector from channel 0, one-hot per channel
    assign ack_offset = exc_ack_vector - `VEC_EXT_BASE;
    assign ext_ack_hot = ext_ack_any ? (6'h01 << ack_offset[2:0]) : 6'h00;

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_EXT; ch = ch + 1) begin : g_ext
            ext_req_channel u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .req_pin_n(ext_req_pin_n[ch]),
                .sense_edge(sense_q[ch]),
                .standby_clr(stby_s2_q),
                .status_read(status_read),
                .status_write(status_write),
                .status_wdata(hwdata[ch]),
                .ack(ext_ack_hot[ch]),
                .flag_q(ext_req_flag[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // nonmaskable request: edge chosen by software, pending until acked
    // a level held on the pin raises one request only; a new edge is
    // needed for the next one
    assign nm_edge_sel = sys_ctrl_q[`BIT_NONMASK_EDGE];
    assign nm_event = nm_edge_sel ? (~nm_prev_q & nm_s2_q)
        : (nm_prev_q & ~nm_s2_q);

    // set wins over the acknowledge clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nm_pend_q <= 1'b0;
        end else if (nm_event) begin
            nm_pend_q <= 1'b1;
        end else if (exc_ack && exc_ack_vector == `VEC_NONMASK) begin
            nm_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a channel takes part only while its flag and its enable are both set
    assign ext_active = ext_req_flag & enable_q[5:0];

    // candidate requests in ascending vector order
    assign src_req = {periph_req, ext_active};

    // priority level per candidate
    // bits 5, 4, 1 and 0 of priority B feed nothing here: they are
    // storage only
    always @* begin
        src_lvl[0] = prio_a_q[7];
        src_lvl[1] = prio_a_q[6];
        src_lvl[3:2] = {2{prio_a_q[5]}};
        src_lvl[5:4] = {2{prio_a_q[4]}};
        src_lvl[7:6] = {2{prio_a_q[3]}};
        src_lvl[10:8] = {3{prio_a_q[2]}};
        src_lvl[13:11] = {3{prio_a_q[1]}};
        src_lvl[16:14] = {3{prio_a_q[0]}};
        src_lvl[20:17] = {4{prio_b_q[`BIT_PRIO_TMR8_CH01]}};
        src_lvl[24:21] = {4{prio_b_q[`BIT_PRIO_TMR8_CH23]}};
        src_lvl[28:25] = {4{prio_b_q[`BIT_PRIO_SERIAL_CH0]}};
        src_lvl[32:29] = {4{prio_b_q[`BIT_PRIO_SERIAL_CH1]}};
    end

    // best candidate: level 1 first, then the smallest vector
    prio_select u_sel (
        .req(src_req),
        .level(src_lvl),
        .found(sel_found),
        .index(sel_index)
    );

    // vector of the chosen candidate
    always @* begin
        sel_vector = src_vector(sel_index);
    end

    ////////////////////////////////////////////////////////////////////////
    // registered request to the cpu; nonmaskable ignores mask and wins
    // cpu_int_mask stands for every mask bit of the core; how the core
    // derives it is outside this block
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
            irq_vector <= 8'h00;
            nonmask_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            nonmask_req <= nm_pend_q;
            if (nm_pend_q) begin
                irq_req <= 1'b1;
                irq_vector <= `VEC_NONMASK;
            end else begin
                irq_req <= sel_found & ~cpu_int_mask;
                irq_vector <= sel_found ? sel_vector : 8'h00;
            end
            // only the nonmaskable input and channels 0..2 may wake
            // the mask does not hold off a wake: the core sorts that out once awake
            wake_req <= sw_standby
                & (nm_pend_q | (|ext_active[2:0]));
        end
    end

endmodule

// File: irq_ctrl_properties.sv
module irq_ctrl_checker (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // cpu side
    input wire cpu_int_mask,
    input wire sw_standby,
    input wire irq_req,
    input wire [7:0] irq_vector,
    input wire nonmask_req,
    input wire wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // a transfer counts only when the bus is ready
    wire taken = hsel && htrans[1] && hready;
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    ////////////////////////////////////////////////////////////
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_one_wait: assert property (taken && !hwrite |=> rd_wait)
        else $error("read wait not one cycle");
    a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    // vector and pending flag register in the same cycle; the past term only adds a cycle of margin
    a_nonmask_on_top: assert property (
        nonmask_req && $past(nonmask_req) |-> irq_vector == 8'h07)
        else $error("nonmask not offered first");
    a_mask_holds_off: assert property (
        $past(cpu_int_mask) && !nonmask_req && !$past(nonmask_req) |-> !irq_req)
        else $error("masked request offered");
    a_wake_in_standby: assert property (
        wake_req |-> $past(sw_standby))
        else $error("wake outside standby");
    a_reset_quiet: assert property (
        $rose(hresetn) |-> !irq_req && !nonmask_req && !wake_req)
        else $error("request right after reset");
endmodule

bind external_irq_priority_ctrl irq_ctrl_checker u_irq_ctrl_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_int_mask(cpu_int_mask), .sw_standby(sw_standby),
    .irq_req(irq_req), .irq_vector(irq_vector), .nonmask_req(nonmask_req),
    .wake_req(wake_req)
);

// File: cpu_exc_model.sv
module cpu_exc_model (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bench controls
    input wire ack_en,
    input wire slow,
    // offered request
    input wire irq_req,
    input wire nonmask_req,
    input wire [7:0] irq_vector,
    // acknowledge
    output logic exc_ack,
    output logic [7:0] exc_ack_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] age_q;
    logic [2:0] hold_q;
    // takes the offered vector promptly or late, then backs off until
    // the request has had time to fall, so one event is not taken twice
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_q <= 3'h0;
            hold_q <= 3'h0;
            exc_ack <= 1'b0;
            exc_ack_vector <= 8'h00;
        end else begin
            exc_ack <= 1'b0;
            exc_ack_vector <= ~exc_ack_vector; // junk outside a pulse
            if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end else if (ack_en && (irq_req || nonmask_req)) begin
                age_q <= age_q + 3'h1;
                if (age_q >= (slow ? 3'h5 : 3'h0)) begin
                    exc_ack <= 1'b1;
                    exc_ack_vector <= irq_vector;
                    age_q <= 3'h0;
                    hold_q <= 3'h4;
                end
            end
        end
    end
endmodule

// File: external_irq_priority_ctrl_tb.sv
`include "irq_ctrl_defs.vh"

module external_irq_priority_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic nonmask_pin = 1'b1;
    logic [5:0] ext_req_pin_n = 6'h3f;
    logic hw_standby = 1'b0;
    logic [26:0] periph_req = 27'h0;
    logic sw_standby = 1'b0;
    logic cpu_int_mask = 1'b0;
    logic ack_en = 1'b0;
    logic slow = 1'b0;
    wire hreadyout, hresp, exc_ack, irq_req, nonmask_req, wake_req;
    wire [31:0] hrdata;
    wire [7:0] exc_ack_vector, irq_vector;
    logic [31:0] rd_q;
    logic v_req, v_nm, v_wk;
    logic [7:0] v_vec, d;
    int err_total = 0;
    int checked = 0;
    int ch, i;
    int pidx[4] = '{11, 15, 19, 23};
    int pbit[4] = '{7, 6, 3, 2};
    int pvec[4] = '{36, 40, 52, 56};

    always #2.5 hclk = ~hclk;

    // hsize is fixed: only whole words are ever moved
    external_irq_priority_ctrl u_external_irq_priority_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .nonmask_pin(nonmask_pin),
        .ext_req_pin_n(ext_req_pin_n), .hw_standby(hw_standby),
        .periph_req(periph_req), .sw_standby(sw_standby),
        .cpu_int_mask(cpu_int_mask), .exc_ack(exc_ack),
        .exc_ack_vector(exc_ack_vector), .irq_req(irq_req),
        .irq_vector(irq_vector), .nonmask_req(nonmask_req), .wake_req(wake_req)
    );
    cpu_exc_model u_cpu_exc_model (
        .hclk(hclk), .hresetn(hresetn), .ack_en(ack_en), .slow(slow),
        .irq_req(irq_req), .nonmask_req(nonmask_req), .irq_vector(irq_vector),
        .exc_ack(exc_ack), .exc_ack_vector(exc_ack_vector)
    );
    ////////////////////////////////////////////////////////////
    function logic [7:0] ext_vec(input int c);
        ext_vec = `VEC_EXT_BASE + 8'(c);
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ready and read data are taken at the rising edge that ends the phase
    task xfer;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_q = hrdata;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        xfer();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        xfer();
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd_q, {24'h0, e});
    endtask
    task look(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
        v_req = irq_req;
        v_nm = nonmask_req;
        v_wk = wake_req;
        v_vec = irq_vector;
        @(posedge hclk);
    endtask
    task regs_zero;
        rchk(`OFS_SYS_CTRL, `RST_SYS_CTRL);
        rchk(`OFS_SENSE, 8'h00);
        rchk(`OFS_ENABLE, 8'h00);
        rchk(`OFS_STATUS, 8'h00);
        rchk(`OFS_PRIO_B, 8'h00);
        rchk(`OFS_PRIO_A, 8'h00);
        rchk(8'h40, 8'h00);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // far beyond the few hundred cycles the sequence needs
    initial begin
        #50000;
        err_total++;
        end_of_test();
    end

    initial begin
        void'($urandom(24835));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        regs_zero();
        // plain storage, read-only zeros and an unmapped word
        repeat (4) begin
            d = 8'($urandom);
            bus(1'b1, `OFS_PRIO_B, d);
            rchk(`OFS_PRIO_B, d);
            bus(1'b1, `OFS_PRIO_A, d);
            rchk(`OFS_PRIO_A, d);
            bus(1'b1, `OFS_ENABLE, d);
            rchk(`OFS_ENABLE, d);
            bus(1'b1, `OFS_SENSE, d);
            rchk(`OFS_SENSE, d);
            bus(1'b1, `OFS_STATUS, d);
            rchk(`OFS_STATUS, 8'h00);
            bus(1'b1, 8'h3c, d);
            rchk(8'h3c, 8'h00);
        end
        bus(1'b1, `OFS_PRIO_B, 8'h00);
        bus(1'b1, `OFS_PRIO_A, 8'h00);
        bus(1'b1, `OFS_SENSE, 8'h00);
        // level sensing per channel, gated by enable, cleared by ack
        sw_standby <= 1'b1;
        ack_en <= 1'b1;
        for (ch = 0; ch < 6; ch++) begin
            slow <= 1'($urandom);
            bus(1'b1, `OFS_ENABLE, 8'h00);
            ext_req_pin_n[ch] <= 1'b0;
            look(6);
            chk(v_req, 1'b0);
            rchk(`OFS_STATUS, 8'h01 << ch);
            bus(1'b1, `OFS_ENABLE, 8'h01 << ch);
            look(3);
            chk({v_req, v_vec}, {1'b1, ext_vec(ch)});
            chk(v_wk, ch < 3);
            ext_req_pin_n[ch] <= 1'b1;
            look(20);
            chk(v_req, 1'b0);
            rchk(`OFS_STATUS, 8'h00);
        end
        sw_standby <= 1'b0;
        ack_en <= 1'b0;
        // edge sensing and the read-then-write-0 clear
        ch = $urandom % 6;
        bus(1'b1, `OFS_SENSE, 8'h3f);
        ext_req_pin_n[ch] <= 1'b0;
        look(4);
        ext_req_pin_n[ch] <= 1'b1;
        look(4);
        bus(1'b1, `OFS_STATUS, 8'h00);
        rchk(`OFS_STATUS, 8'h01 << ch);
        bus(1'b1, `OFS_STATUS, 8'h00);
        rchk(`OFS_STATUS, 8'h00);
        bus(1'b1, `OFS_STATUS, 8'hff);
        rchk(`OFS_STATUS, 8'h00);
        bus(1'b1, `OFS_ENABLE, 8'h01 << ch);
        ack_en <= 1'b1;
        ext_req_pin_n[ch] <= 1'b0;
        look(20);
        chk(v_req, 1'b0);
        rchk(`OFS_STATUS, 8'h00);
        ext_req_pin_n[ch] <= 1'b1;
        ack_en <= 1'b0;
        // group levels against the default order
        for (i = 0; i < 4; i++) begin
            periph_req <= 27'h1 | (27'h1 << pidx[i]);
            look(3);
            chk(v_vec, 8'd20);
            bus(1'b1, `OFS_PRIO_B, 8'($urandom) & 8'h33);
            look(3);
            chk(v_vec, 8'd20);
            bus(1'b1, `OFS_PRIO_B, 8'h01 << pbit[i]);
            look(3);
            chk(v_vec, 8'(pvec[i]));
            bus(1'b1, `OFS_PRIO_B, 8'h00);
        end
        periph_req <= 27'h4;
        look(3);
        chk(v_vec, 8'd24);
        // nonmaskable: beats the mask, both edge choices
        cpu_int_mask <= 1'b1;
        look(3);
        chk(v_req, 1'b0);
        nonmask_pin <= 1'b0;
        look(4);
        chk({v_nm, v_vec}, {1'b1, `VEC_NONMASK});
        ack_en <= 1'b1;
        look(12);
        chk(v_nm, 1'b0);
        ack_en <= 1'b0;
        bus(1'b1, `OFS_SYS_CTRL, `RST_SYS_CTRL | 8'h04);
        nonmask_pin <= 1'b1;
        look(4);
        chk(v_nm, 1'b1);
        ack_en <= 1'b1;
        look(12);
        ack_en <= 1'b0;
        nonmask_pin <= 1'b0;
        look(6);
        chk(v_nm, 1'b0);
        cpu_int_mask <= 1'b0;
        periph_req <= 27'h0;
        // hardware standby returns every register to its reset value
        bus(1'b1, `OFS_PRIO_B, 8'hff);
        bus(1'b1, `OFS_ENABLE, 8'hff);
        hw_standby <= 1'b1;
        look(4);
        hw_standby <= 1'b0;
        look(3);
        regs_zero();
        end_of_test();
    end
endmodule
